// *** logic/bmr_decoder.sv ***
// top: boot region remap decoder, routes master addresses to rom, sram or ext cs0
// Behaviour
// - first fetch after reset at address zero reaches a valid boot memory
// - addresses zero to 0x000F_FFFF route to the selected boot memory
// - strap high at reset maps boot window to embedded rom
// - strap low at reset maps boot window to external chip select zero
// - strap choice only applies while remap is clear; remap clear at reset
// - software sets remap after boot; then sram answers at zero
// - every memory always reachable at its own fixed base
// - static memory controller resets to byte select, 16-bit, cs strobes
// - sram always at 0x0030_0000, and after remap also at zero
// - rom always decoded at 0x0040_0000
`timescale 1ns/1ps
module bmr_decoder
  import bmr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              boot_select_pin,
  input  wire logic              remap_set,
  input  wire logic              remap_clear,
  input  wire logic              req_valid,
  input  wire logic [ADDR_W-1:0] req_addr,
  output logic                   req_stall,
  output logic                   rom_sel,
  output logic                   sram_sel,
  output logic                   ext_chip_select_zero,
  output logic                   abort,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   remap_active,
  output logic                   boot_from_rom,
  output logic [1:0]             static_memory_ctrl_width,
  output logic                   static_memory_ctrl_byte_sel,
  output logic                   static_memory_ctrl_cs_strobe
);
  bmr_strap_if strap ();
  logic           remap_q;
  logic           remap_d;
  logic           rom_sel_q;
  logic           rom_sel_d;
  logic           sram_sel_q;
  logic           sram_sel_d;
  logic           ext_cs0_q;
  logic           ext_cs0_d;
  logic           abort_q;
  logic           abort_d;
  logic           stall_q;
  logic           take_d;
  logic [31:0]    mem_addr_q;
  logic [31:0]    mem_addr_d;
  bmr_target_type tgt_d;
  logic           boot_rom_q;
  logic [1:0]     smc_width_q;
  logic           smc_byte_sel_q;
  logic           smc_cs_strobe_q;

  bmr_strap_capture u_strap (
    .clk             (clk),
    .rstn            (rstn),
    .boot_select_pin (boot_select_pin),
    .strap           (strap)
  );

  // boot window owner; remap overrides the strap
  function automatic bmr_target_type boot_target(input logic remap,
                                                 input logic rom_strap);
    bmr_target_type t;
    if (remap) begin
      t = BMR_TGT_SRAM;
    end else if (rom_strap) begin
      t = BMR_TGT_ROM;
    end else begin
      t = BMR_TGT_EXT;
    end
    return t;
  endfunction

  // offset inside the target; small memories alias across the window
  function automatic logic [31:0] target_offset(input bmr_target_type t,
                                                input logic [31:0]    a);
    logic [31:0] o;
    case (t)
      BMR_TGT_ROM:  o = a & ROM_OFS_MASK;
      BMR_TGT_SRAM: o = a & SRAM_OFS_MASK;
      BMR_TGT_EXT:  o = a & EXT_OFS_MASK;
      default:      o = a;
    endcase
    return o;
  endfunction

  // set wins over a same-cycle clear so a racing clear cannot undo boot code
  always_comb begin
    remap_d = remap_q;
    if (remap_set) begin
      remap_d = 1'b1;
    end else if (remap_clear) begin
      remap_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remap_q <= 1'b0;
    end else begin
      remap_q <= remap_d;
    end
  end

  // fixed bases are checked first so no boot setting can hide them
  always_comb begin
    tgt_d = BMR_TGT_NONE;
    if (bmr_in_range(req_addr, ROM_BASE, ROM_LAST)) begin
      tgt_d = BMR_TGT_ROM;
    end else if (bmr_in_range(req_addr, SRAM_BASE, SRAM_LAST)) begin
      tgt_d = BMR_TGT_SRAM;
    end else if (bmr_in_range(req_addr, EXT_CS0_BASE, EXT_CS0_LAST)) begin
      tgt_d = BMR_TGT_EXT;
    end else if (bmr_in_range(req_addr, BOOT_BASE, BOOT_LAST)) begin
      tgt_d = boot_target(remap_q, strap.boot_rom);
    end
  end

  assign mem_addr_d = target_offset(tgt_d, req_addr);
  assign take_d     = req_valid && !stall_q;

  // requests wait until the strap is known, so the first fetch never misroutes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stall_q <= 1'b1;
    end else begin
      stall_q <= !strap.valid;
    end
  end

  // one select per taken request, none while stalled
  always_comb begin
    rom_sel_d  = take_d && (tgt_d == BMR_TGT_ROM);
    sram_sel_d = take_d && (tgt_d == BMR_TGT_SRAM);
    ext_cs0_d  = take_d && (tgt_d == BMR_TGT_EXT);
    abort_d    = take_d && (tgt_d == BMR_TGT_NONE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rom_sel_q <= 1'b0;
    end else begin
      rom_sel_q <= rom_sel_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sram_sel_q <= 1'b0;
    end else begin
      sram_sel_q <= sram_sel_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_cs0_q <= 1'b0;
    end else begin
      ext_cs0_q <= ext_cs0_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_d;
    end
  end

  // offset only moves on a taken request so a target sees a steady address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_addr_q <= 32'h0000_0000;
    end else if (take_d) begin
      mem_addr_q <= mem_addr_d;
    end
  end

  assign req_stall                    = stall_q;
  assign rom_sel                      = rom_sel_q;
  assign sram_sel                     = sram_sel_q;
  assign ext_chip_select_zero         = ext_cs0_q;
  assign abort                        = abort_q;
  assign mem_addr                     = mem_addr_q;
  assign remap_active                 = remap_q;
  assign boot_from_rom                = boot_rom_q;
  assign static_memory_ctrl_width     = smc_width_q;
  assign static_memory_ctrl_byte_sel  = smc_byte_sel_q;
  assign static_memory_ctrl_cs_strobe = smc_cs_strobe_q;

  // captured strap, visible once the stall drops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_rom_q <= 1'b0;
    end else begin
      boot_rom_q <= strap.boot_rom;
    end
  end

  // cs0 reset timing mode is constant; software retunes it elsewhere
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      smc_width_q <= SMC_WIDTH_16;
    end else begin
      smc_width_q <= SMC_WIDTH_16;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      smc_byte_sel_q <= SMC_BYTE_SEL;
    end else begin
      smc_byte_sel_q <= SMC_BYTE_SEL;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      smc_cs_strobe_q <= SMC_STROBE_CS;
    end else begin
      smc_cs_strobe_q <= SMC_STROBE_CS;
    end
  end
endmodule

// *** logic/bmr_pkg.sv ***
// package: address map and selector codes for the boot remap decoder
package bmr_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam logic [31:0] BOOT_BASE     = 32'h0000_0000;
  localparam logic [31:0] BOOT_LAST     = 32'h000F_FFFF;
  localparam logic [31:0] SRAM_BASE     = 32'h0030_0000;
  localparam logic [31:0] SRAM_LAST     = 32'h0030_FFFF;
  localparam logic [31:0] ROM_BASE      = 32'h0040_0000;
  localparam logic [31:0] ROM_LAST      = 32'h0040_7FFF;
  localparam logic [31:0] EXT_CS0_BASE  = 32'h1000_0000;
  localparam logic [31:0] EXT_CS0_LAST  = 32'h1FFF_FFFF;
  localparam logic [31:0] SRAM_OFS_MASK = 32'h0000_FFFF;
  localparam logic [31:0] ROM_OFS_MASK  = 32'h0000_7FFF;
  localparam logic [31:0] EXT_OFS_MASK  = 32'h0FFF_FFFF;
  localparam logic        BOOT_PIN_ROM  = 1'b1;
  localparam logic [1:0]  SMC_WIDTH_16  = 2'b01;
  localparam logic        SMC_BYTE_SEL  = 1'b1;
  localparam logic        SMC_STROBE_CS = 1'b1;
  typedef enum logic [3:0] {
    BMR_TGT_NONE = 4'b0001,
    BMR_TGT_ROM  = 4'b0010,
    BMR_TGT_SRAM = 4'b0100,
    BMR_TGT_EXT  = 4'b1000
  } bmr_target_type;
  typedef enum logic [2:0] {
    BMR_BOOT_WAIT = 3'b001,
    BMR_BOOT_ROM  = 3'b010,
    BMR_BOOT_EXT  = 3'b100
  } bmr_boot_type;
  function automatic logic bmr_in_range(input logic [31:0] a, input logic [31:0] lo,
                                        input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

// *** logic/bmr_strap_capture.sv ***
// module: synchronises and captures the boot select strap once after reset
`timescale 1ns/1ps
module bmr_strap_capture
  import bmr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic boot_select_pin,
  bmr_strap_if.cap  strap
);
  logic sync1_q;
  logic sync2_q;
  bmr_boot_type state_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= boot_select_pin;
      sync2_q <= sync1_q;
    end
  end

  // two arming cycles: the chain's reset zeros must flush before the pin is trusted
  logic [1:0] arm_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arm_q <= 2'h0;
    end else begin
      arm_q <= {arm_q[0], 1'b1};
    end
  end

  // captured once, held until next reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= BMR_BOOT_WAIT;
    end else begin
      case (state_q)
        BMR_BOOT_WAIT: begin
          if (arm_q[1]) begin
            state_q <= (sync2_q == BOOT_PIN_ROM) ? BMR_BOOT_ROM : BMR_BOOT_EXT;
          end
        end
        BMR_BOOT_ROM: state_q <= BMR_BOOT_ROM;
        BMR_BOOT_EXT: state_q <= BMR_BOOT_EXT;
        default:      state_q <= BMR_BOOT_WAIT;
      endcase
    end
  end

  assign strap.valid    = (state_q != BMR_BOOT_WAIT);
  assign strap.boot_rom = (state_q == BMR_BOOT_ROM);
endmodule

// *** logic/bmr_strap_if.sv ***
// interface: captured boot strap between capture and decode
`timescale 1ns/1ps
interface bmr_strap_if;
  logic valid;
  logic boot_rom;
  modport cap (output valid, output boot_rom);
  modport dec (input valid, input boot_rom);
endinterface

// *** test/bmr_decoder_checker.sv ***
// checker: port assertions for the boot remap decoder
`timescale 1ns/1ps
module bmr_decoder_checker
  import bmr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        remap_set,
  input wire logic        req_valid,
  input wire logic [31:0] req_addr,
  input wire logic        req_stall,
  input wire logic        rom_sel,
  input wire logic        sram_sel,
  input wire logic        ext_chip_select_zero,
  input wire logic        abort,
  input wire logic [31:0] mem_addr,
  input wire logic        remap_active,
  input wire logic        boot_from_rom
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // same-edge remap set left out (a same-edge clear is not): decode order there is a design choice
  wire       tk  = req_valid && !req_stall && !remap_set;
  wire       bw  = tk && req_addr <= BOOT_LAST;
  wire [3:0] hit = {rom_sel, sram_sel, ext_chip_select_zero, abort};
  a_boot_rom_map: assert property (bw && !remap_active && boot_from_rom |=> rom_sel)
    else $error("boot window missed rom");
  a_boot_ext_map: assert property (bw && !remap_active && !boot_from_rom |=> hit == 4'h2)
    else $error("boot window missed ext cs0");
  a_remap_sram: assert property (bw && remap_active |=> sram_sel)
    else $error("remapped window missed sram");
  a_sram_fixed: assert property (tk && req_addr inside {[SRAM_BASE:SRAM_LAST]} |=>
    sram_sel && mem_addr == ($past(req_addr) & SRAM_OFS_MASK)) else $error("sram base missed");
  a_rom_fixed: assert property (tk && req_addr inside {[ROM_BASE:ROM_LAST]} |=> rom_sel)
    else $error("rom base missed");
  a_one_target: assert property ($onehot0(hit))
    else $error("several targets at once");
  a_stall_quiet: assert property (req_stall |=> hit == 4'h0)
    else $error("target while stalled");
  a_strap_hold: assert property (!req_stall |=> $stable(boot_from_rom))
    else $error("strap changed after capture");
  a_remap_sticks: assert property (remap_set |=> remap_active)
    else $error("remap not taken");
  cover property (bw && remap_active);
  cover property (bw && !boot_from_rom);
  cover property (bw && boot_from_rom);
  cover property (req_stall && req_valid);
endmodule

// *** test/bmr_master_model.sv ***
// model: bus master and boot software driving the decoder
`timescale 1ns/1ps
module bmr_master_model (
  input  wire logic        clk,
  output logic             req_valid,
  output logic [31:0]      req_addr,
  output logic             remap_set,
  output logic             remap_clear,
  input  wire logic [3:0]  hit,
  input  wire logic [31:0] mem_addr
);
  initial begin
    req_valid   = 1'b0;
    req_addr    = 32'h0000_0000;
    remap_set   = 1'b0;
    remap_clear = 1'b0;
  end
  // released address shows the inverse, not the last value
  task automatic req(input logic [31:0] a, output logic [3:0] s, output logic [31:0] o);
    @(negedge clk);
    req_valid = 1'b1;
    req_addr  = a;
    @(negedge clk);
    req_valid = 1'b0;
    req_addr  = ~a;
    s = hit;
    o = mem_addr;
  endtask
  task automatic remap(input logic on);
    @(negedge clk);
    remap_set   = on;
    remap_clear = !on;
    @(negedge clk);
    remap_set   = 1'b0;
    remap_clear = 1'b0;
  endtask
endmodule

// *** test/boot_memory_remap_decoder_tb.sv ***
// testbench: boot remap decoder scenarios
`timescale 1ns/1ps
module boot_memory_remap_decoder_tb;
  import bmr_pkg::*;
  logic clk, rstn, boot_select_pin, remap_set, remap_clear, req_valid, req_stall;
  logic rom_sel, sram_sel, ext_chip_select_zero, abort, remap_active, boot_from_rom;
  logic static_memory_ctrl_byte_sel, static_memory_ctrl_cs_strobe;
  logic [1:0]  static_memory_ctrl_width;
  logic [31:0] req_addr, mem_addr;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  bmr_decoder u_bmr_decoder (.*);
  bmr_master_model u_bmr_master_model (.clk, .req_valid, .req_addr, .remap_set, .remap_clear,
    .hit({rom_sel, sram_sel, ext_chip_select_zero, abort}), .mem_addr);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go(input logic [31:0] a, input logic [3:0] es, input logic [31:0] eo);
    logic [3:0]  s;
    logic [31:0] o;
    u_bmr_master_model.req(a, s, o);
    chk("target", {28'h0, s}, {28'h0, es});
    chk("offset", o, eo);
  endtask
  // strap held steady across release so capture sees one level
  task automatic boot(input logic p);
    @(negedge clk);
    rstn = 1'b0;
    boot_select_pin = p;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    go(32'h0000_0000, 4'h0, 32'h0000_0000);
    for (int i = 0; i < 20 && req_stall !== 1'b0; i++) @(negedge clk);
    chk("stall", {31'h0, req_stall}, 32'h0);
    chk("strap", {31'h0, boot_from_rom}, {31'h0, p});
  endtask
  task automatic t_ext_boot;
    boot(1'b0);
    chk("smc", {28'h0, static_memory_ctrl_width, static_memory_ctrl_byte_sel,
      static_memory_ctrl_cs_strobe}, {28'h0, SMC_WIDTH_16, SMC_BYTE_SEL, SMC_STROBE_CS});
    go(32'h0000_0004, 4'h2, 32'h0000_0004);
    go(32'h1000_0010, 4'h2, 32'h0000_0010);
    go(32'h0010_0000, 4'h1, 32'h0010_0000);
  endtask
  task automatic t_remap;
    u_bmr_master_model.remap(1'b1);
    chk("remap", {31'h0, remap_active}, 32'h0000_0001);
    go(32'h0000_0100, 4'h4, 32'h0000_0100);
    go(32'h0040_0000, 4'h8, 32'h0000_0000);
    u_bmr_master_model.remap(1'b0);
    go(32'h0000_0000, 4'h2, 32'h0000_0000);
  endtask
  task automatic t_rom_boot;
    boot(1'b1);
    chk("remap", {31'h0, remap_active}, 32'h0);
    go(32'h0000_0000, 4'h8, 32'h0000_0000);
    go(32'h000F_FFFC, 4'h8, 32'h0000_7FFC);
    boot_select_pin = 1'b0;
    go(32'h0030_0008, 4'h4, 32'h0000_0008);
    go(32'h0000_0010, 4'h8, 32'h0000_0010);
    chk("strap", {31'h0, boot_from_rom}, 32'h0000_0001);
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up;
    end
  end
  initial begin
    rstn = 1'b0;
    boot_select_pin = 1'b1;
    t_ext_boot;
    t_remap;
    t_rom_boot;
    wrap_up;
  end
endmodule
bind bmr_decoder bmr_decoder_checker u_bmr_decoder_checker (.*);
